// File: core/ipc_pkg.sv
/*
 * Constants of the interrupt priority configuration bank: register offsets,
 * writable masks, reset values, level codes and the source table.
 * Assumes it is compiled before every other file of the block.
 */
package ipc_pkg;
    // Widths of the register data, offsets, vector numbers and levels.
    localparam int DATA_W    = 16;
    localparam int OFF_W     = 5;
    localparam int VEC_W     = 7;
    localparam int LVL_W     = 2;
    localparam int REG_COUNT = 24;
    // The offset window that the block decodes, holes included.
    localparam int WINDOW_WORDS = 32;

    // Register offsets within the block.
    localparam logic [4:0] OFF_PRIO0        = 5'h00;
    localparam logic [4:0] OFF_PRIO1        = 5'h01;
    localparam logic [4:0] OFF_PRIO2        = 5'h02;
    localparam logic [4:0] OFF_PRIO3        = 5'h03;
    localparam logic [4:0] OFF_PRIO9        = 5'h09;
    localparam logic [4:0] OFF_VBASE        = 5'h0A;
    localparam logic [4:0] OFF_FAST0_MATCH  = 5'h0B;
    localparam logic [4:0] OFF_FAST1_VEC_HI = 5'h10;
    localparam logic [4:0] OFF_PEND0        = 5'h11;
    localparam logic [4:0] OFF_PEND5        = 5'h16;
    localparam logic [4:0] OFF_CTRL         = 5'h1D;
    localparam logic [4:0] OFF_PRIO10       = 5'h1F;

    // Storage slots of the plain read/write registers in the small memory.
    localparam logic [3:0] SLOT_CTRL   = 4'hD;
    localparam logic [3:0] SLOT_PRIO10 = 4'hE;
    localparam int         STORE_DEPTH = 16;

    // Writable bits of the three laid-out priority registers.
    localparam logic [15:0] MASK_PRIO0 = 16'h3C00;
    localparam logic [15:0] MASK_PRIO1 = 16'h003F;
    localparam logic [15:0] MASK_PRIO2 = 16'hFFCF;
    localparam logic [15:0] RESET_REG = 16'h0000;

    // Field code that disables a request source.
    localparam logic [1:0] CODE_OFF = 2'h0;

    // Source table: register, field low bit, debug class and vector number.
    localparam int NUM_FIELDS = 12;
    localparam int SRC_REG [NUM_FIELDS] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2};
    localparam int SRC_LSB [NUM_FIELDS] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0};
    localparam bit SRC_DEBUG [NUM_FIELDS] = '{1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0};
    localparam logic [6:0] SRC_VEC [NUM_FIELDS] = '{7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C,
        7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13};
endpackage : ipc_pkg

// File: core/ipc_store_if.sv
/*
 * Bundle between the register front end and the storage memory.
 * Assumes one clock; the memory answers a read one edge after it is asked.
 */
`timescale 1ns/1ps
`default_nettype none
interface ipc_store_if;
    logic        we;     // Write strobe, one cycle.
    logic [3:0]  wIdx;   // Slot written.
    logic [15:0] wData;  // Data written.
    logic        re;     // Read strobe, one cycle.
    logic [3:0]  rIdx;   // Slot read.
    logic [15:0] rData;  // Registered read data.

    // The front end asks, the memory answers.
    modport ctrl (output we, wIdx, wData, re, rIdx, input rData);
    modport store (input we, wIdx, wData, re, rIdx, output rData);
endinterface : ipc_store_if
`default_nettype wire

// File: core/ipc_reg_store.sv
/*
 * Small memory that holds the plain read/write registers of the bank.
 * Assumes the front end decodes slots; read data come out of a register.
 */
`timescale 1ns/1ps
`default_nettype none
module ipc_reg_store #(
    parameter int DEPTH = ipc_pkg::STORE_DEPTH
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    ipc_store_if.store  port
);
    // Storage words; reset so that software never reads an unknown.
    logic [15:0] mem [DEPTH];

    // Writes land on the clock edge; a frozen clock enable holds everything.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= ipc_pkg::RESET_REG;
            end
        end else if (ce && port.we) begin
            mem[port.wIdx] <= port.wData;
        end
    end

    // Read data are registered, which costs one cycle but keeps timing clean.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.rData <= ipc_pkg::RESET_REG;
        end else if (ce && port.re) begin
            port.rData <= mem[port.rIdx];
        end
    end
endmodule : ipc_reg_store
`default_nettype wire

// File: core/ipc_priority_bank.sv
/*
 * Priority configuration bank of the interrupt controller: register port,
 * priority fields, pending view and the level/vector selection.
 * Assumes a bus master that holds address and data for the strobe cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ipc_priority_bank #(
    parameter int                ADDR_W  = 24,
    parameter logic [ADDR_W-1:0] BASE    = 24'h00F1A0,
    parameter int                NUM_SRC = 86
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic                 wr,
    input  wire logic                 rd,
    input  wire logic [15:0]          wdata,
    output logic      [15:0]          rdata,
    output logic                      rdValid,
    input  wire logic [NUM_SRC-1:0]   irqReq,
    output logic                      irqValid,
    output logic      [1:0]           irqLevel,
    output logic      [6:0]           irqVector,
    output logic      [22:0]          vecAddr
);
    localparam int NF      = ipc_pkg::NUM_FIELDS;
    localparam int PEND_W  = 6 * ipc_pkg::DATA_W;

    // Address decode against the system base.
    logic [ADDR_W-1:0] diff;      // Address minus the base.
    logic              hit;       // Address falls in the block's window.
    logic [4:0]        off;       // Register offset.
    logic [4:0]        slotW;     // Memory slot of the offset, valid in bit 4.
    logic [4:0]        slotR;     // Memory slot of the offset read in stage one.

    // Priority registers, base register and pending image.
    logic [15:0]        prio0;    // Breakpoint and step counter fields.
    logic [15:0]        prio1;    // Receive, transmit and trace fields.
    logic [15:0]        prio2;    // Flash and system fields.
    logic [15:0]        vecBase;  // Vector base.
    logic [NUM_SRC-1:0] pendReq;  // Requests registered once.
    logic [PEND_W-1:0]  pendWide; // Pending image padded to six words.
    logic [2:0]         pendSel;  // Pending word selected by a read.

    // Read pipeline.
    logic              rdPend;    // Stage one holds a read.
    logic [4:0]        rdOff;     // Offset of that read.
    logic [15:0]       readMux;   // Data chosen for the answer.
    logic [15:0]       pendWord;  // Pending word of that read.

    // Per-source decode.
    logic [15:0]       prioWord [3];
    logic [1:0]        fieldCode [NF];
    logic [1:0]        srcLvl [NF];
    logic [NF-1:0]     srcAct;

    // Next values of the selection outputs.
    logic              next_irqValid;
    logic [1:0]        next_irqLevel;
    logic [6:0]        next_irqVector;

    // Maps an offset to a storage slot; bit 4 says the offset lives there.
    function automatic logic [4:0] slotOf(input logic [4:0] o);
        logic [4:0] s;
        s = 5'h00;
        if (o >= ipc_pkg::OFF_PRIO3 && o <= ipc_pkg::OFF_PRIO9) begin
            s = {1'b1, 4'(o - ipc_pkg::OFF_PRIO3)};
        end else if (o >= ipc_pkg::OFF_FAST0_MATCH && o <= ipc_pkg::OFF_FAST1_VEC_HI) begin
            s = {1'b1, 4'(o - 5'h04)};
        end else if (o == ipc_pkg::OFF_CTRL) begin
            s = {1'b1, ipc_pkg::SLOT_CTRL};
        end else if (o == ipc_pkg::OFF_PRIO10) begin
            s = {1'b1, ipc_pkg::SLOT_PRIO10};
        end
        return s;
    endfunction : slotOf

    // The window is the base plus the decoded offsets; holes answer zero.
    assign diff  = addr - BASE;
    assign hit   = (addr >= BASE) && (diff < ADDR_W'(ipc_pkg::WINDOW_WORDS));
    assign off   = diff[4:0];
    assign slotW = slotOf(off);
    assign slotR = slotOf(rdOff);

    // Plain registers go to the memory; the interface carries the strobes.
    ipc_store_if storeBus ();
    assign storeBus.we    = wr && hit && slotW[4];
    assign storeBus.wIdx  = slotW[3:0];
    assign storeBus.wData = wdata;
    assign storeBus.re    = rd && hit && slotW[4];
    assign storeBus.rIdx  = slotW[3:0];

    ipc_reg_store #(
        .DEPTH (ipc_pkg::STORE_DEPTH)
    ) u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .port  (storeBus)
    );

    // Priority registers 0 to 2 keep only their field bits; the rest stay zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio0 <= ipc_pkg::RESET_REG;
            prio1 <= ipc_pkg::RESET_REG;
            prio2 <= ipc_pkg::RESET_REG;
            vecBase <= ipc_pkg::RESET_REG;
        end else if (ce && wr && hit) begin
            if (off == ipc_pkg::OFF_PRIO0) begin
                prio0 <= wdata & ipc_pkg::MASK_PRIO0;
            end
            if (off == ipc_pkg::OFF_PRIO1) begin
                prio1 <= wdata & ipc_pkg::MASK_PRIO1;
            end
            if (off == ipc_pkg::OFF_PRIO2) begin
                prio2 <= wdata & ipc_pkg::MASK_PRIO2;
            end
            if (off == ipc_pkg::OFF_VBASE) begin
                vecBase <= wdata;
            end
        end
    end

    // Requests are registered once so arbitration sees a stable image.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendReq <= '0;
        end else if (ce) begin
            pendReq <= irqReq;
        end
    end

    // Pending words beyond the last source read as zero.
    assign pendWide = PEND_W'(pendReq);
    assign pendSel  = 3'(rdOff - ipc_pkg::OFF_PEND0);
    assign pendWord = pendWide[pendSel*16 +: 16];

    // Answer mux; offsets with no register give zero.
    assign readMux =
        (rdOff == ipc_pkg::OFF_PRIO0) ? prio0   :
        (rdOff == ipc_pkg::OFF_PRIO1) ? prio1   :
        (rdOff == ipc_pkg::OFF_PRIO2) ? prio2   :
        (rdOff == ipc_pkg::OFF_VBASE) ? vecBase :
        (rdOff >= ipc_pkg::OFF_PEND0 && rdOff <= ipc_pkg::OFF_PEND5) ? pendWord :
        slotR[4] ? storeBus.rData : 16'h0000;

    // Stage one remembers the read while the memory fetches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdPend <= 1'b0;
            rdOff  <= 5'h00;
        end else if (ce) begin
            rdPend <= rd && hit;
            rdOff  <= off;
        end
    end

    // Stage two drives the answer for exactly one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdValid <= 1'b0;
            rdata   <= 16'h0000;
        end else if (ce) begin
            rdValid <= rdPend;
            rdata   <= rdPend ? readMux : 16'h0000;
        end
    end

    // Field decode per source; debug fields map straight, flash ones drop one.
    assign prioWord[0] = prio0;
    assign prioWord[1] = prio1;
    assign prioWord[2] = prio2;
    for (genvar i = 0; i < NF; i++) begin : g_src
        assign fieldCode[i] = prioWord[ipc_pkg::SRC_REG[i]][ipc_pkg::SRC_LSB[i] +: 2];
        assign srcLvl[i] = ipc_pkg::SRC_DEBUG[i] ? fieldCode[i]
                                                 : fieldCode[i] - 2'h1;
        assign srcAct[i] = (fieldCode[i] != ipc_pkg::CODE_OFF)
                           && pendReq[ipc_pkg::SRC_VEC[i]];
    end

    // Highest level wins; on a tie the lower vector number wins, because the
    // scan runs downward and an equal level replaces the earlier choice.
    always_comb begin
        next_irqValid  = 1'b0;
        next_irqLevel  = 2'h0;
        next_irqVector = 7'h00;
        for (int i = NF - 1; i >= 0; i--) begin
            if (srcAct[i] && (!next_irqValid || srcLvl[i] >= next_irqLevel)) begin
                next_irqValid  = 1'b1;
                next_irqLevel  = srcLvl[i];
                next_irqVector = ipc_pkg::SRC_VEC[i];
            end
        end
    end

    // Selection outputs are registered, so a field write shows one edge later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqValid  <= 1'b0;
            irqLevel  <= 2'h0;
            irqVector <= 7'h00;
            vecAddr   <= 23'h000000;
        end else if (ce) begin
            irqValid  <= next_irqValid;
            irqLevel  <= next_irqLevel;
            irqVector <= next_irqVector;
            vecAddr   <= {vecBase, next_irqVector};
        end
    end

    // Reserved bits of priority registers 0 and 2 never hold a one.
    property p_rsv_zero;
        @(posedge clk) disable iff (!rst_n)
        ((prio0 & ~ipc_pkg::MASK_PRIO0) == 16'h0000) && ((prio2 & 16'h0030) == 16'h0000);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");

    // An offset in a hole answers zero two edges after the read.
    property p_hole_zero;
        @(posedge clk) disable iff (!rst_n)
        (rd && ce && addr == BASE + ADDR_W'(5'h17)) ##1 ce |=> rdValid && rdata == 16'h0000;
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("hole read not zero");

    // A write at base plus one lands in priority register 1.
    property p_base_add;
        @(posedge clk) disable iff (!rst_n)
        (wr && ce && addr == BASE + ADDR_W'(ipc_pkg::OFF_PRIO1))
            |=> prio1 == ($past(wdata) & ipc_pkg::MASK_PRIO1);
    endproperty
    a_base_add: assert property (p_base_add) else $error("offset write missed");

    // A debug source reports the level equal to its code.
    property p_debug_lvl;
        @(posedge clk) disable iff (!rst_n)
        irqValid && irqVector == ipc_pkg::SRC_VEC[0] && $past(ce)
            |-> irqLevel == $past(prio0[13:12]) && irqLevel != 2'h0;
    endproperty
    a_debug_lvl: assert property (p_debug_lvl) else $error("debug level wrong");

    // A flash source reports its code minus one and never level three.
    property p_flash_lvl;
        @(posedge clk) disable iff (!rst_n)
        irqValid && irqVector == ipc_pkg::SRC_VEC[5] && $past(ce)
            |-> irqLevel == 2'($past(prio2[15:14]) - 2'h1) && irqLevel != 2'h3;
    endproperty
    a_flash_lvl: assert property (p_flash_lvl) else $error("flash level wrong");

    // Right after reset every field is disabled.
    property p_reset_off;
        @(posedge clk) $rose(rst_n) |-> prio0 == 16'h0000 && prio1 == 16'h0000
            && prio2 == 16'h0000 && !irqValid;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("field not reset");

    // Register 1 holds nothing above bit 5.
    property p_prio1_layout;
        @(posedge clk) disable iff (!rst_n)
        $changed(prio1) |-> prio1[15:6] == 10'h000 && prio1[5:0] == $past(wdata[5:0]);
    endproperty
    a_prio1_layout: assert property (p_prio1_layout) else $error("register 1 layout");

    // Register 2 keeps both flash fields as written.
    property p_prio2_layout;
        @(posedge clk) disable iff (!rst_n)
        (wr && ce && addr == BASE + ADDR_W'(ipc_pkg::OFF_PRIO2))
            |=> prio2[15:12] == $past(wdata[15:12]);
    endproperty
    a_prio2_layout: assert property (p_prio2_layout) else $error("register 2 layout");

    // Register 0 keeps both debug fields as written.
    property p_prio0_layout;
        @(posedge clk) disable iff (!rst_n)
        (wr && ce && addr == BASE + ADDR_W'(ipc_pkg::OFF_PRIO0))
            |=> prio0[13:10] == $past(wdata[13:10]) && prio0[9:0] == 10'h000;
    endproperty
    a_prio0_layout: assert property (p_prio0_layout) else $error("register 0 layout");

    // The lowest source at level three always wins the next cycle.
    property p_lowest_wins;
        @(posedge clk) disable iff (!rst_n)
        ce && srcAct[0] && srcLvl[0] == 2'h3
            |=> irqValid && irqVector == ipc_pkg::SRC_VEC[0] && irqLevel == 2'h3;
    endproperty
    a_lowest_wins: assert property (p_lowest_wins) else $error("tie not resolved");

    // The vector address joins the base register and the vector.
    property p_vec_addr;
        @(posedge clk) disable iff (!rst_n)
        irqValid && $past(ce) |-> vecAddr == {$past(vecBase), irqVector};
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

    // A field written, left idle one cycle and then read comes back four
    // edges after the write; the idle cycle keeps a second write out.
    property p_readback;
        @(posedge clk) disable iff (!rst_n)
        (wr && ce && addr == BASE + ADDR_W'(ipc_pkg::OFF_PRIO0)) ##1 (ce && !wr)
            ##1 (rd && ce && addr == BASE + ADDR_W'(ipc_pkg::OFF_PRIO0)) ##1 ce
            |=> rdValid && rdata == ($past(wdata, 4) & ipc_pkg::MASK_PRIO0);
    endproperty
    a_readback: assert property (p_readback) else $error("read back mismatch");
endmodule : ipc_priority_bank
`default_nettype wire

// File: testbench/ipc_core_model.sv
/*
 * Bus-master model of the processor core that reaches the priority bank.
 * Assumes the bench calls its tasks from one process, one access at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module ipc_core_model #(
    parameter int ADDR_W = 24
) (
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] addr,
    output logic                   wr,
    output logic                   rd,
    output logic      [15:0]       wdata,
    input  wire logic [15:0]       rdata,
    input  wire logic              rdValid
);
    // The bus is idle at time zero.
    initial begin
        addr  = '0;
        wr    = 1'b0;
        rd    = 1'b0;
        wdata = 16'h0000;
    end

    // One write; afterwards the data lines show the inverse so stale data cannot pass.
    task automatic put(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : put

    // One read; the answer is awaited for a bounded number of edges.
    task automatic get(input logic [ADDR_W-1:0] a, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        d  = 16'h0000;
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        for (int n = 0; n < 6 && !ok; n++) begin
            @(posedge clk);
            if (rdValid === 1'b1) begin
                ok = 1'b1;
                d  = rdata;
            end
        end
    endtask : get
endmodule : ipc_core_model
`default_nettype wire

// File: testbench/irq_priority_config_bank_bench.sv
/*
 * Self-checking bench of the priority bank against a behavioural model.
 * Assumes the design package is compiled first and one 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module irq_priority_config_bank_bench;
    localparam logic [23:0] BASE = 24'h00F1A0; // System base of the bank.
    logic        clk, rstN, ce, wr, rd, rdValid, irqValid;
    logic [23:0] addr;
    logic [15:0] wdata, rdata;
    logic [85:0] irqReq;
    logic [1:0]  irqLevel;
    logic [6:0]  irqVector;
    logic [22:0] vecAddr;
    logic [15:0] mem [32]; // Model of every offset in the window.
    int          seed, n_mismatch, total_checks;

    ipc_priority_bank #(.BASE(BASE)) DUT (.clk(clk), .rst_n(rstN), .ce(ce), .addr(addr),
        .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .rdValid(rdValid), .irqReq(irqReq),
        .irqValid(irqValid), .irqLevel(irqLevel), .irqVector(irqVector), .vecAddr(vecAddr));
    ipc_core_model core (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .rdValid(rdValid));

    // Free-running clock of 4 ns.
    always #2 clk = ~clk;

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // Counts one comparison and reports it at once if it failed.
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    // Writable bits of each offset; reserved, read-only and holes keep nothing.
    function automatic logic [15:0] wmask(input int off);
        if (off == 0) return 16'h3C00;
        if (off == 1) return 16'h003F;
        if (off == 2) return 16'hFFCF;
        if (off <= 16 || off == 29 || off == 31) return 16'hFFFF;
        return 16'h0000;
    endfunction : wmask

    // Expected read value; pending words mirror the request lines.
    function automatic logic [15:0] expRd(input int off);
        logic [95:0] pend;
        pend = {10'h000, irqReq};
        if (off >= 17 && off <= 22) return pend[(off - 17) * 16 +: 16];
        return mem[off];
    endfunction : expRd

    task automatic wreg(input int off, input logic [15:0] d);
        core.put(BASE + 24'(off), d);
        mem[off] = (mem[off] & ~wmask(off)) | (d & wmask(off));
    endtask : wreg

    task automatic rreg(input int off);
        logic [15:0] d;
        bit          ok;
        core.get(BASE + 24'(off), d, ok);
        chk(ok && d === expRd(off), "register read differs from model");
    endtask : rreg

    // Model of the selection: highest level wins, a tie goes to the lower source.
    task automatic chkArb();
        int code, lvl, bestL, bestV;
        bestL = -1;
        bestV = 0;
        for (int i = 0; i < 12; i++) begin
            code = int'(mem[ipc_pkg::SRC_REG[i]] >> ipc_pkg::SRC_LSB[i]) & 3;
            lvl  = ipc_pkg::SRC_DEBUG[i] ? code : code - 1;
            if (code != 0 && irqReq[8 + i] === 1'b1 && lvl > bestL) begin
                bestL = lvl;
                bestV = 8 + i;
            end
        end
        chk(irqValid === (bestL >= 0), "request valid flag");
        if (bestL >= 0) begin
            chk(irqLevel === 2'(bestL) && irqVector === 7'(bestV), "winner");
            chk(vecAddr === {mem[10], 7'(bestV)}, "vector address");
        end else chk(irqLevel === 2'h0, "idle level");
    endtask : chkArb

    // Changes the request lines, then lets them pass the two-stage path.
    task automatic setReq(input logic [85:0] v);
        @(posedge clk);
        irqReq <= v;
        repeat (3) @(posedge clk);
    endtask : setReq

    // Main sequence.
    initial begin
        logic [15:0] d;
        bit          ok;
        clk = 1'b0;
        rstN = 1'b0;
        ce = 1'b1;
        irqReq = '0;
        seed = 93;
        n_mismatch = 0;
        total_checks = 0;
        foreach (mem[i]) mem[i] = 16'h0000;
        repeat (3) @(posedge clk);
        rstN <= 1'b1;
        setReq(86'({$random(seed), $random(seed), $random(seed)}));
        chkArb();
        for (int o = 0; o < 32; o++) rreg(o);
        // Every offset is written with random data; outside addresses must not alias.
        for (int o = 0; o < 32; o++) wreg(o, 16'($random(seed)));
        core.put(BASE - 24'h000001, 16'hFFFF);
        core.put(BASE + 24'h000020, 16'hFFFF);
        for (int o = 0; o < 32; o++) rreg(o);
        core.get(BASE + 24'h000020, d, ok);
        chk(!ok, "read answered outside the window");
        // A write made while the clock enable is low must not land.
        ce <= 1'b0;
        core.put(BASE + 24'h000003, ~mem[3]);
        ce <= 1'b1;
        rreg(3);
        // A field written and read right after comes back as written.
        wreg(0, 16'($random(seed)));
        rreg(0);
        // Each source alone at every field code.
        for (int i = 0; i < 12; i++) begin
            for (int c = 0; c < 4; c++) begin
                wreg(ipc_pkg::SRC_REG[i], 16'(c << ipc_pkg::SRC_LSB[i]));
                setReq(86'(1) << (8 + i));
                chkArb();
            end
        end
        // Random fields, base and requests compete.
        for (int n = 0; n < 40; n++) begin
            wreg(0, 16'($random(seed)));
            wreg(1, 16'($random(seed)));
            wreg(2, 16'($random(seed)));
            wreg(10, 16'($random(seed)));
            setReq(86'({$random(seed), $random(seed), $random(seed)}));
            chkArb();
            rreg(17 + n % 6);
        end
        close_out();
    end

    // Watchdog against a hung handshake.
    initial begin
        #160000;
        n_mismatch++;
        close_out();
    end
endmodule : irq_priority_config_bank_bench
`default_nettype wire
